/* File: logic/gate_cfg_params.svh */
// Purpose: Named constants for the gate driver protection register bank
// Assumes: 40 MHz aclk; register index times four gives the byte address
// Notes:   Definitions only
`ifndef GATE_CFG_PARAMS_SVH
`define GATE_CFG_PARAMS_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define CLK_MHZ             40
`define DEAD_BASE_NS        50
`define DEAD_BASE_CYC       (((`DEAD_BASE_NS * `CLK_MHZ) + 999) / 1000)
`define DEG_BASE_US         1
`define DEG_BASE_CYC        (`DEG_BASE_US * `CLK_MHZ)
`define RETRY_LONG_MS       8
`define RETRY_LONG_CYC      (`RETRY_LONG_MS * 1000 * `CLK_MHZ)
`define RETRY_SHORT_US      50
`define RETRY_SHORT_CYC     (`RETRY_SHORT_US * `CLK_MHZ)
`define RETRY_CNT_W         19
`define DEG_CNT_W           9
`define DEAD_CNT_W          6

// ----------------------------------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define ADDR_LSB            2
`define IDX_W               4
`define REG_OCP_IDX         4'h5
`define REG_CSA_IDX         4'h6
`define REG_DRV_IDX         4'h7
`define REG_CTRL_IDX        4'h8
`define REG_STAT_IDX        4'h9
`define REG_W               11

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define OCP_RST             11'h169
`define CSA_RST             11'h283
`define DRV_RST             11'h000
`define CYCLE_CLR_RST       1'b1

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define OCP_RETRY_BIT       10
`define OCP_DEAD_LSB        8
`define OVERCURRENT_RESPONSE_LSB        6
`define OVERCURRENT_FILTER_TIME_LSB         4
`define OCP_VDS_LSB         0
`define CSA_AMPSEL_BIT      10
`define CSA_REFHALF_BIT     9
`define CSA_LSREF_BIT       8
`define AMP_GAIN_SELECT_LSB        6
`define CSA_SHDIS_BIT       5
`define CSA_CALA_BIT        4
`define CSA_CALB_BIT        3
`define CSA_CALC_BIT        2
`define CSA_SHLVL_LSB       0
`define DRV_CALMODE_BIT     0
`define CTRL_CLR_BIT        0
`define CTRL_CYCLE_BIT      1
`define STAT_REPORT_BIT     0
`define STAT_DISABLE_BIT    1
`define STAT_VDS_BIT        2
`define STAT_SHUNT_BIT      3

// ----------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------
`define MODE_LATCH          2'b00
`define MODE_RETRY          2'b01
`define MODE_REPORT         2'b10
`define MODE_IGNORE         2'b11
`define RESP_OKAY           2'b00
`define RESP_DECERR         2'b11
`define PIN_VDS             0
`define PIN_SHUNT           1
`define PIN_PWM             2
`define PIN_N               3

`endif

/* File: logic/gate_cfg_pkg.sv */
// Purpose: Types for the gate driver protection register bank
// Assumes: gate_cfg_params.svh supplies widths
// Notes:   One packed struct holds all state of the top module
`include "gate_cfg_params.svh"

package gate_cfg_pkg;

    // ----------------------------------------------------------------
    // Fault handling states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_REPORT,
        ST_LATCHED,
        ST_RETRY
    } fault_state_t;

    typedef logic [`REG_W-1:0] reg_word_t;

    // ----------------------------------------------------------------
    // Whole module state
    // ----------------------------------------------------------------
    typedef struct packed {
        reg_word_t                ocp;
        reg_word_t                csa;
        reg_word_t                drv;
        logic                     cycle_clear;
        logic                     clear_req;
        logic [`PIN_N-1:0]        sy1;
        logic [`PIN_N-1:0]        sy2;
        logic [`PIN_N-1:0]        sy3;
        logic [`PIN_N-1:0]        flt;
        logic [`DEG_CNT_W-1:0]    deg_cnt;
        logic [`RETRY_CNT_W-1:0]  retry_cnt;
        fault_state_t             state;
        logic                     cause_vds;
        logic                     cause_shunt;
        logic                     aw_got;
        logic                     w_got;
        logic [`IDX_W-1:0]        aw_idx;
        logic [31:0]              wdata;
        logic [3:0]               wstrb;
        logic                     bvalid;
        logic [1:0]               bresp;
        logic                     rvalid;
        logic [31:0]              rdata;
        logic [1:0]               rresp;
    } state_t;

endpackage

/* File: logic/gate_cfg_regs.sv */
// Purpose: Protection and sense configuration registers with overcurrent fault handling
// Assumes: AXI4-Lite master with at most one read and one write in flight
// Notes:   Overcurrent and PWM pins are asynchronous and pass three flops
//
// Contract
// - Faults clear after retry interval: 8 ms when select is 0, 50 us when 1.
// - Dead time from two-bit code: 50, 100, 200 or 400 ns.
// - Response code 00 latches the fault until explicitly cleared.
// - Response code 01 clears the fault automatically after the retry interval.
// - Response code 10 only reports, no protective action on outputs.
// - Response code 11 neither reports nor acts.
// - Overcurrent must persist 1, 2, 4 or 8 us before recognition.
// - Amp input select at 1 routes switch node and forces low-side ref to 1.
// - Reference halving bit: 0 full reference, 1 half reference.
// - Low-side ref bit picks shunt positive or negative node for measurement.
// - Two-bit gain code selects 5, 10, 20 or 40 V/V.
// - Shunt fault disable at 1 suppresses the shunt overcurrent fault.
// - Each offset short bit shorts its own amplifier inputs when 1.
// - Two-bit code sets shunt trip level 0.25, 0.5, 0.75 or 1 V.
// - Calibration method bit: 0 manual, 1 automatic routine.
// - Sense control and driver config registers exist only on amplifier variants.
// - All three registers read and write; reserved bits reset to zero.
// - In retry mode, cycle clear option lets a new PWM input clear faults.
// - Protection control register sits at index 0x05.
`timescale 1ns/1ps
`include "gate_cfg_params.svh"

module gate_cfg_regs #(
    parameter int HAS_SENSE_AMPS  = 1,
    parameter int RETRY_LONG_CYC  = `RETRY_LONG_CYC
) (
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    input  wire logic [7:0]               s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    input  wire logic [7:0]               s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    input  wire logic                     drain_source_overcurrent,
    input  wire logic                     shunt_overcurrent,
    input  wire logic                     pwm_input,
    output logic                          fault_report,
    output logic                          gate_disable,
    output logic [`DEAD_CNT_W-1:0]        dead_time_cycles,
    output logic [3:0]                    drain_source_trip_level,
    output logic                          amp_input_select,
    output logic                          ref_half_select,
    output logic                          low_side_ref_select,
    output logic [1:0]                    amp_gain_select,
    output logic                          shunt_fault_enable,
    output logic                          amp_a_offset_short,
    output logic                          amp_b_offset_short,
    output logic                          amp_c_offset_short,
    output logic [1:0]                    shunt_trip_level,
    output logic                          auto_cal_select
);
    import gate_cfg_pkg::*;

    localparam logic [`RETRY_CNT_W-1:0] RETRY_LONG  = RETRY_LONG_CYC[`RETRY_CNT_W-1:0];
    localparam logic [`RETRY_CNT_W-1:0] RETRY_SHORT = `RETRY_CNT_W'(`RETRY_SHORT_CYC);
    localparam logic [`DEG_CNT_W-1:0]   DEG_BASE    = `DEG_CNT_W'(`DEG_BASE_CYC);
    localparam logic [`DEAD_CNT_W-1:0]  DEAD_BASE   = `DEAD_CNT_W'(`DEAD_BASE_CYC);
    localparam logic                    AMPS        = (HAS_SENSE_AMPS != 0);

    state_t r_r;
    state_t r_nxt;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Byte lanes 0 and 1 cover the 11 live bits
    function automatic reg_word_t merge(input reg_word_t old, input logic [31:0] d,
                                        input logic [3:0] strb);
        reg_word_t v;
        v = old;
        if (strb[0]) begin
            v[7:0] = d[7:0];
        end
        if (strb[1]) begin
            v[10:8] = d[10:8];
        end
        return v;
    endfunction

    // Known register index for this variant
    // variant decode
    function automatic logic mapped(input logic [`IDX_W-1:0] idx);
        logic m;
        m = 1'b0;
        case (idx)
            `REG_OCP_IDX:  m = 1'b1;
            `REG_CSA_IDX:  m = AMPS;
            `REG_DRV_IDX:  m = AMPS;
            `REG_CTRL_IDX: m = 1'b1;
            `REG_STAT_IDX: m = 1'b1;
            default:       m = 1'b0;
        endcase
        return m;
    endfunction

    // ----------------------------------------------------------------
    // Decoded configuration
    // ----------------------------------------------------------------
    logic [1:0]               mode;
    logic [1:0]               deg_code;
    logic [1:0]               dead_code;
    logic                     shunt_en;
    logic                     oc_now;
    logic                     recognized;
    logic                     pwm_edge;
    logic                     pwm_stable;
    logic [`DEG_CNT_W-1:0]    deg_limit;
    logic [`RETRY_CNT_W-1:0]  retry_limit;
    logic [31:0]              rd_word;
    logic [`IDX_W-1:0]        ar_idx;

    // Field views of the stored words, effective from the cycle after a write
    // combinational views, no register stage beyond the stored word
    assign mode      = r_r.ocp[`OVERCURRENT_RESPONSE_LSB +: 2];
    assign deg_code  = r_r.ocp[`OVERCURRENT_FILTER_TIME_LSB +: 2];
    assign dead_code = r_r.ocp[`OCP_DEAD_LSB +: 2];
    assign shunt_en  = AMPS & ~r_r.csa[`CSA_SHDIS_BIT];
    assign deg_limit = DEG_BASE << deg_code;
    assign retry_limit = r_r.ocp[`OCP_RETRY_BIT] ? RETRY_SHORT : RETRY_LONG;

    // Filtered pin levels and, for the PWM edge, sync stages two and three; the first sync stage is never looked at here
    assign oc_now     = r_r.flt[`PIN_VDS] | (r_r.flt[`PIN_SHUNT] & shunt_en);
    assign recognized = oc_now && (r_r.deg_cnt == deg_limit);
    assign pwm_stable = (r_r.sy2[`PIN_PWM] == r_r.sy3[`PIN_PWM]);
    assign pwm_edge   = pwm_stable && r_r.sy3[`PIN_PWM] && !r_r.flt[`PIN_PWM];
    assign ar_idx     = s_axi_araddr[`ADDR_LSB +: `IDX_W];

    // ----------------------------------------------------------------
    // Read multiplexer
    // ----------------------------------------------------------------
    // Unused and unmapped bits read as zero
    always_comb begin
        rd_word = 32'h0000_0000;
        case (ar_idx)
            `REG_OCP_IDX: begin
                rd_word[`REG_W-1:0] = r_r.ocp;
            end
            `REG_CSA_IDX: begin
                rd_word[`REG_W-1:0] = AMPS ? r_r.csa : '0;
            end
            `REG_DRV_IDX: begin
                rd_word[`REG_W-1:0] = AMPS ? r_r.drv : '0;
            end
            `REG_CTRL_IDX: begin
                rd_word[`CTRL_CYCLE_BIT] = r_r.cycle_clear;
            end
            `REG_STAT_IDX: begin
                rd_word[`STAT_REPORT_BIT]  = (r_r.state != ST_IDLE);
                rd_word[`STAT_DISABLE_BIT] = (r_r.state == ST_LATCHED) ||
                                             (r_r.state == ST_RETRY);
                rd_word[`STAT_VDS_BIT]     = r_r.cause_vds;
                rd_word[`STAT_SHUNT_BIT]   = r_r.cause_shunt;
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        r_nxt           = r_r;
        r_nxt.clear_req = 1'b0;

        // Three-flop synchronisers; level accepted when stages two and three agree
        r_nxt.sy1 = {pwm_input, shunt_overcurrent, drain_source_overcurrent};
        r_nxt.sy2 = r_r.sy1;
        r_nxt.sy3 = r_r.sy2;
        for (int i = 0; i < `PIN_N; i++) begin
            if (r_r.sy2[i] == r_r.sy3[i]) begin
                r_nxt.flt[i] = r_r.sy3[i];
            end
        end

        if (!oc_now) begin
            r_nxt.deg_cnt = '0;
        end else if (r_r.deg_cnt < deg_limit) begin
            r_nxt.deg_cnt = r_r.deg_cnt + 1'b1;
        end

        // Fault handling
        case (r_r.state)
            ST_IDLE: begin
                if (recognized) begin
                    r_nxt.cause_vds   = r_r.flt[`PIN_VDS];
                    r_nxt.cause_shunt = r_r.flt[`PIN_SHUNT] & shunt_en;
                    r_nxt.retry_cnt   = '0;
                    case (mode)
                        `MODE_LATCH:  r_nxt.state = ST_LATCHED;
                        `MODE_RETRY:  r_nxt.state = ST_RETRY;
                        `MODE_REPORT: r_nxt.state = ST_REPORT;
                        default:      r_nxt.state = ST_IDLE;
                    endcase
                end
            end
            ST_REPORT: begin
                // Reported while the recognised condition lasts
                if (!recognized) begin
                    r_nxt.state = ST_IDLE;
                end
            end
            ST_LATCHED: begin
                // clear loses to a fresh event
                if (r_r.clear_req && !recognized) begin
                    r_nxt.state = ST_IDLE;
                end
            end
            ST_RETRY: begin
                r_nxt.retry_cnt = r_r.retry_cnt + 1'b1;
                if (r_r.retry_cnt >= retry_limit - 1'b1) begin
                    r_nxt.state = ST_IDLE;
                end
                if (r_r.cycle_clear && pwm_edge) begin
                    r_nxt.state = ST_IDLE;
                end
            end
            default: begin
                r_nxt.state = ST_IDLE;
            end
        endcase
        // leaving a fault when ignoring is selected
        if (mode == `MODE_IGNORE) begin
            r_nxt.state = ST_IDLE;
        end
        if (r_nxt.state == ST_IDLE) begin
            r_nxt.cause_vds   = 1'b0;
            r_nxt.cause_shunt = 1'b0;
        end

        // AXI write address and data, taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            r_nxt.aw_got = 1'b1;
            r_nxt.aw_idx = s_axi_awaddr[`ADDR_LSB +: `IDX_W];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            r_nxt.w_got = 1'b1;
            r_nxt.wdata = s_axi_wdata;
            r_nxt.wstrb = s_axi_wstrb;
        end
        if (r_r.bvalid && s_axi_bready) begin
            r_nxt.bvalid = 1'b0;
        end

        // Commit once both halves are held
        if (r_r.aw_got && r_r.w_got && !r_r.bvalid) begin
            r_nxt.aw_got = 1'b0;
            r_nxt.w_got  = 1'b0;
            r_nxt.bvalid = 1'b1;
            r_nxt.bresp  = mapped(r_r.aw_idx) ? `RESP_OKAY : `RESP_DECERR;
            case (r_r.aw_idx)
                `REG_OCP_IDX: begin
                    r_nxt.ocp = merge(r_r.ocp, r_r.wdata, r_r.wstrb);
                end
                `REG_CSA_IDX: begin
                    if (AMPS) begin
                        r_nxt.csa = merge(r_r.csa, r_r.wdata, r_r.wstrb);
                        if (r_nxt.csa[`CSA_AMPSEL_BIT]) begin
                            r_nxt.csa[`CSA_LSREF_BIT] = 1'b1;
                        end
                    end
                end
                `REG_DRV_IDX: begin
                    if (AMPS) begin
                        r_nxt.drv = merge(r_r.drv, r_r.wdata, r_r.wstrb);
                    end
                end
                `REG_CTRL_IDX: begin
                    if (r_r.wstrb[0]) begin
                        r_nxt.cycle_clear = r_r.wdata[`CTRL_CYCLE_BIT];
                        r_nxt.clear_req   = r_r.wdata[`CTRL_CLR_BIT];
                    end
                end
                default: begin
                    r_nxt.clear_req = 1'b0;
                end
            endcase
        end

        // AXI read, one outstanding
        if (r_r.rvalid && s_axi_rready) begin
            r_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            r_nxt.rvalid = 1'b1;
            r_nxt.rdata  = rd_word;
            r_nxt.rresp  = mapped(ar_idx) ? `RESP_OKAY : `RESP_DECERR;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // deglitch 4 us and level 1001b chosen as reset values
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_r             <= '0;
            r_r.ocp         <= `OCP_RST;
            r_r.csa         <= `CSA_RST;
            r_r.drv         <= `DRV_RST;
            r_r.cycle_clear <= `CYCLE_CLR_RST;
            r_r.state       <= ST_IDLE;
        end else begin
            r_r <= r_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Handshake readies are combinational; a held response blocks new requests
    assign s_axi_awready = !r_r.aw_got && !r_r.bvalid;
    assign s_axi_wready  = !r_r.w_got && !r_r.bvalid;
    assign s_axi_bvalid  = r_r.bvalid;
    assign s_axi_bresp   = r_r.bresp;
    assign s_axi_arready = !r_r.rvalid;
    assign s_axi_rvalid  = r_r.rvalid;
    assign s_axi_rdata   = r_r.rdata;
    assign s_axi_rresp   = r_r.rresp;

    assign fault_report  = (r_r.state != ST_IDLE);
    // outputs held off while latched or retrying
    assign gate_disable  = (r_r.state == ST_LATCHED) || (r_r.state == ST_RETRY);
    assign dead_time_cycles        = DEAD_BASE << dead_code;
    assign drain_source_trip_level = r_r.ocp[`OCP_VDS_LSB +: 4];

    // Sense amplifier controls, held at zero on variants without amplifiers
    // input routing
    assign amp_input_select    = AMPS & r_r.csa[`CSA_AMPSEL_BIT];
    assign ref_half_select     = AMPS & r_r.csa[`CSA_REFHALF_BIT];
    assign low_side_ref_select = AMPS & r_r.csa[`CSA_LSREF_BIT];
    assign amp_gain_select     = AMPS ? r_r.csa[`AMP_GAIN_SELECT_LSB +: 2] : 2'h0;
    assign shunt_fault_enable  = shunt_en;
    assign amp_a_offset_short  = AMPS & r_r.csa[`CSA_CALA_BIT];
    assign amp_b_offset_short  = AMPS & r_r.csa[`CSA_CALB_BIT];
    assign amp_c_offset_short  = AMPS & r_r.csa[`CSA_CALC_BIT];
    assign shunt_trip_level    = AMPS ? r_r.csa[`CSA_SHLVL_LSB +: 2] : 2'h0;
    assign auto_cal_select     = AMPS & r_r.drv[`DRV_CALMODE_BIT];

endmodule // gate_cfg_regs

/* File: verification/gate_cfg_chk.sv */
// Purpose: Port-level checks of the protection register bank
// Assumes: Bound onto the top module, one clock domain
// Notes:   Watches design ports only, both inputs and outputs
`timescale 1ns/1ps
`include "gate_cfg_params.svh"
module gate_cfg_chk (
    input wire logic aclk, aresetn, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bready,
    input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic [31:0] s_axi_rdata,
    input wire logic drain_source_overcurrent, shunt_overcurrent, fault_report, gate_disable,
    input wire logic [`DEAD_CNT_W-1:0] dead_time_cycles,
    input wire logic amp_input_select, low_side_ref_select
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Field and fault relations
    ref_forced_a:
    assert property (amp_input_select |-> low_side_ref_select) else $error("ref not forced");
    dead_code_a:
    assert property (dead_time_cycles inside {6'h2, 6'h4, 6'h8, 6'h10}) else $error("bad dead");
    gate_report_a:
    assert property (gate_disable |-> fault_report) else $error("gate without report");
    deglitch_min_a:
    assert property (!(drain_source_overcurrent || shunt_overcurrent) [*8] |=> !$rose(fault_report))
        else $error("fault without overcurrent");
    // Bus holds an answer until taken, a held write answer keeps write readies low
    bresp_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    rdata_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    read_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
    wr_busy_a:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("ready busy");
    cover property ($rose(gate_disable));
    cover property (fault_report && !gate_disable);
    cover property (s_axi_bvalid && s_axi_bresp == 2'h3);
endmodule // gate_cfg_chk

/* File: verification/fault_src.sv */
// Purpose: Overcurrent and PWM pin source facing the block
// Assumes: Requests arrive from the bench on the clock edge
// Notes:   Pins change one cycle after a request, like a board comparator
`timescale 1ns/1ps
module fault_src (
    input wire logic aclk,
    input wire logic [2:0] req,
    output logic drain_source_overcurrent, shunt_overcurrent, pwm_input
);
    // Registered so pins never move in the sampling step
    always_ff @(posedge aclk) begin
        {pwm_input, shunt_overcurrent, drain_source_overcurrent} <= req;
    end
endmodule // fault_src

/* File: verification/gate_driver_protection_config_regs_tb_top.sv */
// Purpose: Self-checking bench of the protection register bank
// Assumes: AXI4-Lite master tasks, short retry count
// Notes:   Table of register accesses, then fault mode tests
`timescale 1ns/1ps
module gate_driver_protection_config_regs_tb_top;
    typedef struct packed {logic w; logic [7:0] a; logic [31:0] d, e; logic [1:0] r;} row_t;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
    logic [3:0] s_axi_wstrb, drain_source_trip_level;
    logic [1:0] s_axi_bresp, s_axi_rresp, amp_gain_select, shunt_trip_level, resp;
    logic drain_source_overcurrent, shunt_overcurrent, pwm_input, fault_report, gate_disable;
    logic [5:0] dead_time_cycles;
    logic amp_input_select, ref_half_select, low_side_ref_select, shunt_fault_enable;
    logic amp_a_offset_short, amp_b_offset_short, amp_c_offset_short, auto_cal_select;
    logic [2:0] req;
    int miscompares, check_count;
    row_t rows[7] = '{'{0, 8'h14, 0, 32'h169, 0}, '{0, 8'h18, 0, 32'h283, 0},
        '{0, 8'h1c, 0, 0, 0}, '{1, 8'h14, 32'hffffffff, 32'h7ff, 0},
        '{1, 8'h18, 32'h41d, 32'h51d, 0}, '{1, 8'h1c, 32'h1, 32'h1, 0},
        '{1, 8'h3c, 32'h1, 0, 2'h3}};
    gate_cfg_regs #(.RETRY_LONG_CYC(3000)) u_dut (.*);
    fault_src u_src (.aclk(aclk), .req(req), .drain_source_overcurrent(drain_source_overcurrent),
        .shunt_overcurrent(shunt_overcurrent), .pwm_input(pwm_input));
    task automatic end_sim();
        if (miscompares == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // Bounded wait cut short counts as a mismatch
    task automatic give_up(input int n);
        if (n >= 40) begin
            miscompares++;
            end_sim();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 40);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        give_up(n);
    endtask
    task automatic rd(input logic [7:0] a);
        int n = 0;
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 40);
        {rd_v, resp} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
        give_up(n);
    endtask
    initial begin
        aclk = 0;
        forever #12.5 aclk = ~aclk;
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, req} = 0;
        s_axi_wstrb = 4'hf;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        chk({ref_half_select, amp_gain_select, shunt_trip_level}, 5'h1b);
        chk(drain_source_trip_level, 4'h9);
        // Reset values, masking, forced bit, unmapped index
        foreach (rows[i]) begin
            if (rows[i].w) wr(rows[i].a, rows[i].d);
            if (rows[i].w) chk(resp, rows[i].r);
            rd(rows[i].a);
            chk(rd_v, rows[i].e);
            chk(resp, rows[i].r);
        end
        chk(low_side_ref_select, 1);
        chk({amp_a_offset_short, amp_b_offset_short, amp_c_offset_short}, 3'h7);
        chk(shunt_trip_level, 2'h1);
        chk(auto_cal_select, 1);
        wr(8'h1c, 32'h0);
        chk(auto_cal_select, 0);
        for (int k = 0; k < 4; k++) begin
            wr(8'h14, 32'h400 | (k << 8));
            chk(dead_time_cycles, 2 << k);
        end
        // Every response mode, 1 us filter, 50 us retry
        for (int m = 0; m < 4; m++) begin
            wr(8'h14, 32'h400 | (m << 6));
            req <= 3'h1;
            repeat (60) @(posedge aclk);
            chk(fault_report, m != 3);
            chk(gate_disable, m < 2);
            req <= 3'h0;
            repeat (1800) @(posedge aclk);
            chk(gate_disable, m < 2);
            repeat (300) @(posedge aclk);
            chk(gate_disable, m == 0);
            wr(8'h20, 32'h3);
            repeat (3) @(posedge aclk);
            chk(fault_report, 0);
        end
        // A new PWM edge ends a retry long before the interval
        wr(8'h14, 32'h440);
        req <= 3'h1;
        repeat (60) @(posedge aclk);
        chk(gate_disable, 1);
        req <= 3'h4;
        repeat (20) @(posedge aclk);
        chk(gate_disable, 0);
        req <= 3'h0;
        // Shunt fault suppressed, then enabled
        wr(8'h18, 32'h20);
        chk(shunt_fault_enable, 0);
        wr(8'h14, 32'h480);
        req <= 3'h2;
        repeat (60) @(posedge aclk);
        chk(fault_report, 0);
        wr(8'h18, 32'h0);
        repeat (60) @(posedge aclk);
        chk(fault_report, 1);
        req <= 3'h0;
        // Mid-run reset restores defaults and drops the report
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h18);
        chk(rd_v, 32'h283);
        chk(fault_report, 0);
        end_sim();
    end
endmodule // gate_driver_protection_config_regs_tb_top
bind gate_cfg_regs gate_cfg_chk u_chk (.*);
